// >>> logic/thermo_pkg.sv
/*
 * Shared constants and types for the thermostat alarm and result readout block:
 * register pointers, configuration field positions, power-up values, resolution
 * masks and the conversion sequencer states.
 * Assumes one clock domain; the serial protocol engine lives elsewhere.
 */
`default_nettype none
package thermo_pkg;

	// register pointers
	localparam logic [1:0]  PTR_RESULT   = 2'h0;
	localparam logic [1:0]  PTR_CONFIG   = 2'h1;
	localparam logic [1:0]  PTR_RELEASE  = 2'h2;
	localparam logic [1:0]  PTR_OVER     = 2'h3;

	// configuration field positions
	localparam int          CFG_STANDBY  = 0;
	localparam int          CFG_MODE     = 1;
	localparam int          CFG_POL      = 2;
	localparam int          CFG_FQ_LO    = 3;
	localparam int          CFG_FQ_HI    = 4;
	localparam int          CFG_RES_LO   = 5;
	localparam int          CFG_RES_HI   = 6;
	localparam int          CFG_SINGLE   = 7;

	// power-up values
	localparam logic [7:0]  CONFIG_RST   = 8'h00;
	localparam logic [15:0] RELEASE_RST  = 16'h4800;
	localparam logic [15:0] OVER_RST     = 16'h5000;
	localparam logic [15:0] RESULT_RST   = 16'h0000;

	// left-justified data masks per resolution select
	localparam logic [15:0] MASK_9BIT    = 16'hff80;
	localparam logic [15:0] MASK_10BIT   = 16'hffc0;
	localparam logic [15:0] MASK_11BIT   = 16'hffe0;
	localparam logic [15:0] MASK_12BIT   = 16'hfff0;

	// consecutive fault counts per queue select
	localparam logic [2:0]  FAULTS_1     = 3'h1;
	localparam logic [2:0]  FAULTS_2     = 3'h2;
	localparam logic [2:0]  FAULTS_4     = 3'h4;
	localparam logic [2:0]  FAULTS_6     = 3'h6;

	typedef struct packed {
		logic [1:0] res;
		logic [1:0] fq;
		logic       alarm_polarity_bit;
		logic       int_mode;
		logic       standby;
	} config_t;

	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_CONV = 1'b1
	} conv_state_t;

endpackage
`default_nettype wire

// >>> logic/thermo_alarm.sv
/*
 * Thermostat alarm and temperature result readout.
 * Holds result, configuration and both set points, sequences conversions
 * (continuous, standby, single shot) and drives the open-drain alarm pin.
 * Assumes a register port already decoded by a serial engine on clk_i and a
 * converter on clk_i that answers each start pulse with one done pulse.
 */
// Contract
// - result is sixteen-bit two's complement, top bit sign
// - result low four bits always zero
// - result left-justified, unused low bits zero
// - reads return latest result, never disturb conversion
// - set points compared at active resolution only
// - single-conversion in standby runs exactly one conversion
// - alarm polarity follows config, active-low after reset
// - comparator alarm sets after enough over-limit conversions
// - comparator alarm clears after enough below-release conversions
// - comparator alarm unchanged on entering standby
// - interrupt alarm first sets on over-limit count
// - interrupt alarm cleared by standby or any read
// - interrupt alarm then re-arms on release count, alternating
// - fault queue select gives 1, 2, 4, 6
// - alarm acts one conversion after count, if still faulted
// - standby finishes running conversion and stores it
// - entering standby in interrupt mode clears alarm
// - registers work in standby, clearing standby resumes
// - power-up defaults make a standalone thermostat
// - set point registers keep any written value
// - resolution select 9 to 12 bits, default 9
// - single-conversion bit reads back zero
// - set points reset to 4800 and 5000 hex
`timescale 1ns/1ps
`default_nettype none
module thermo_alarm (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        reg_rd_i,
	input  wire logic        reg_wr_i,
	input  wire logic [1:0]  reg_ptr_i,
	input  wire logic [15:0] reg_wdata_i,
	output logic      [15:0] reg_rdata_o,
	output logic             conv_start_o,
	input  wire logic        conv_done_i,
	input  wire logic [11:0] conv_raw_i,
	output logic             alarm_o,
	output logic             alarm_oe_o
);

	function automatic logic [15:0] res_mask(input logic [1:0] sel);
		logic [15:0] m;
		m = thermo_pkg::MASK_9BIT;
		unique case (sel)
			2'h0: m = thermo_pkg::MASK_9BIT;
			2'h1: m = thermo_pkg::MASK_10BIT;
			2'h2: m = thermo_pkg::MASK_11BIT;
			2'h3: m = thermo_pkg::MASK_12BIT;
		endcase
		return m;
	endfunction

	function automatic logic [2:0] fault_target(input logic [1:0] sel);
		logic [2:0] n;
		n = thermo_pkg::FAULTS_1;
		unique case (sel)
			2'h0: n = thermo_pkg::FAULTS_1;
			2'h1: n = thermo_pkg::FAULTS_2;
			2'h2: n = thermo_pkg::FAULTS_4;
			2'h3: n = thermo_pkg::FAULTS_6;
		endcase
		return n;
	endfunction

	thermo_pkg::config_t     cfg_r,      cfg_nxt;
	logic [15:0]             release_r,  release_nxt;
	logic [15:0]             over_r,     over_nxt;
	logic [15:0]             result_r,   result_nxt;
	logic [15:0]             rdata_r,    rdata_nxt;
	logic                    single_r,   single_nxt;
	thermo_pkg::conv_state_t state_r,    state_nxt;
	logic                    alarm_r,    alarm_nxt;
	logic                    hot_wait_r, hot_wait_nxt;
	logic [2:0]              cnt_r,      cnt_nxt;
	logic                    pending_r,  pending_nxt;
	logic                    in_sb_r,    in_sb_nxt;

	logic [15:0] mask;
	logic [15:0] sample;
	logic        hot;
	logic        cold;
	logic        awaited;
	logic        cond;
	logic        go;
	logic        sb_entry;
	logic        cfg_wr;
	logic        pin_low;

	// sample and set points cut to the active resolution
	always_comb begin
		mask    = res_mask(cfg_r.res);
		sample  = {conv_raw_i, 4'h0} & mask;
		hot     = $signed(sample) > $signed(over_r & mask);
		cold    = $signed(sample) < $signed(release_r & mask);
		awaited = cfg_r.int_mode ? hot_wait_r : !alarm_r;
		cond    = awaited ? hot : cold;
		cfg_wr  = reg_wr_i && (reg_ptr_i == thermo_pkg::PTR_CONFIG);
	end

	// register file; host access never touches the sequencer
	always_comb begin
		cfg_nxt     = cfg_r;
		release_nxt = release_r;
		over_nxt    = over_r;
		result_nxt  = result_r;
		rdata_nxt   = rdata_r;
		single_nxt  = single_r;
		if (conv_done_i && state_r == thermo_pkg::ST_CONV) begin
			result_nxt = sample;
			single_nxt = 1'b0;
		end
		if (reg_wr_i) begin
			unique case (reg_ptr_i)
				// read-only: a stray write must not swallow a result stored this cycle
				thermo_pkg::PTR_RESULT:  ;
				thermo_pkg::PTR_CONFIG: begin
					cfg_nxt.standby  = reg_wdata_i[thermo_pkg::CFG_STANDBY];
					cfg_nxt.int_mode = reg_wdata_i[thermo_pkg::CFG_MODE];
					cfg_nxt.alarm_polarity_bit      = reg_wdata_i[thermo_pkg::CFG_POL];
					cfg_nxt.fq       = reg_wdata_i[thermo_pkg::CFG_FQ_HI:thermo_pkg::CFG_FQ_LO];
					cfg_nxt.res      = reg_wdata_i[thermo_pkg::CFG_RES_HI:thermo_pkg::CFG_RES_LO];
				end
				thermo_pkg::PTR_RELEASE: release_nxt = reg_wdata_i;
				thermo_pkg::PTR_OVER:    over_nxt    = reg_wdata_i;
			endcase
		end
		// a request sticks until its conversion is stored
		if (cfg_wr && reg_wdata_i[thermo_pkg::CFG_SINGLE])
			single_nxt = 1'b1;
		if (reg_rd_i) begin
			unique case (reg_ptr_i)
				thermo_pkg::PTR_RESULT:  rdata_nxt = result_r;
				thermo_pkg::PTR_CONFIG:  rdata_nxt = {8'h00, 1'b0, cfg_r.res, cfg_r.fq,
					cfg_r.alarm_polarity_bit, cfg_r.int_mode, cfg_r.standby};
				thermo_pkg::PTR_RELEASE: rdata_nxt = release_r;
				thermo_pkg::PTR_OVER:    rdata_nxt = over_r;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_r     <= thermo_pkg::config_t'(thermo_pkg::CONFIG_RST[6:0]);
			release_r <= thermo_pkg::RELEASE_RST;
			over_r    <= thermo_pkg::OVER_RST;
			result_r  <= thermo_pkg::RESULT_RST;
			rdata_r   <= 16'h0000;
			single_r  <= 1'b0;
		end else begin
			cfg_r     <= cfg_nxt;
			release_r <= release_nxt;
			over_r    <= over_nxt;
			result_r  <= result_nxt;
			rdata_r   <= rdata_nxt;
			single_r  <= single_nxt;
		end
	end

	assign reg_rdata_o = rdata_r;

	// sequencer and alarm
	always_comb begin
		go           = !cfg_r.standby || single_r;
		state_nxt    = state_r;
		alarm_nxt    = alarm_r;
		hot_wait_nxt = hot_wait_r;
		cnt_nxt      = cnt_r;
		pending_nxt  = pending_r;
		in_sb_nxt    = in_sb_r && cfg_r.standby;
		sb_entry     = 1'b0;
		conv_start_o = 1'b0;
		unique case (state_r)
			thermo_pkg::ST_IDLE: begin
				if (go) begin
					conv_start_o = 1'b1;
					state_nxt    = thermo_pkg::ST_CONV;
				end
			end
			thermo_pkg::ST_CONV: begin
				if (conv_done_i) begin
					state_nxt = thermo_pkg::ST_IDLE;
					// a single shot from standby is no fresh entry
					sb_entry  = cfg_r.standby && !in_sb_r;
					if (cfg_r.standby)
						in_sb_nxt = 1'b1;
				end
			end
		endcase
		if (reg_rd_i && cfg_r.int_mode)
			alarm_nxt = 1'b0;
		if (sb_entry && cfg_r.int_mode)
			alarm_nxt = 1'b0;
		if (conv_done_i && state_r == thermo_pkg::ST_CONV) begin
			if (!cond) begin
				cnt_nxt     = 3'h0;
				pending_nxt = 1'b0;
			end else if (pending_r) begin
				// one extra conversion must still fault before acting
				cnt_nxt     = 3'h0;
				pending_nxt = 1'b0;
				if (cfg_r.int_mode) begin
					alarm_nxt    = 1'b1;
					hot_wait_nxt = !hot_wait_r;
				end else begin
					alarm_nxt    = !alarm_r;
				end
			end else begin
				cnt_nxt = cnt_r + 3'h1;
				if (cnt_nxt == fault_target(cfg_r.fq))
					pending_nxt = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r    <= thermo_pkg::ST_IDLE;
			alarm_r    <= 1'b0;
			hot_wait_r <= 1'b1;
			cnt_r      <= 3'h0;
			pending_r  <= 1'b0;
			in_sb_r    <= 1'b0;
		end else begin
			state_r    <= state_nxt;
			alarm_r    <= alarm_nxt;
			hot_wait_r <= hot_wait_nxt;
			cnt_r      <= cnt_nxt;
			pending_r  <= pending_nxt;
			in_sb_r    <= in_sb_nxt;
		end
	end

	// open drain: only a low level is driven
	always_comb begin
		pin_low    = alarm_r ? !cfg_r.alarm_polarity_bit : cfg_r.alarm_polarity_bit;
		alarm_o    = 1'b0;
		alarm_oe_o = pin_low;
	end

	chk_low_nibble_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		result_r[3:0] == 4'h0) else $error("result low bits not zero");

	chk_result_justify: assert property (@(posedge clk_i) disable iff (rst_i)
		(conv_done_i && state_r == thermo_pkg::ST_CONV) |=>
		result_r == ({$past(conv_raw_i), 4'h0} & res_mask($past(cfg_r.res))))
		else $error("result not stored left-justified");

	chk_sign_bit: assert property (@(posedge clk_i) disable iff (rst_i)
		(conv_done_i && state_r == thermo_pkg::ST_CONV) |=> result_r[15] == $past(conv_raw_i[11]))
		else $error("sign bit wrong");

	chk_cfg_single_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		(reg_rd_i && reg_ptr_i == thermo_pkg::PTR_CONFIG) |=> reg_rdata_o[7:0] ==
		{1'b0, $past(cfg_r.res), $past(cfg_r.fq), $past(cfg_r.alarm_polarity_bit), $past(cfg_r.int_mode),
		$past(cfg_r.standby)}) else $error("config readback wrong");

	chk_pin_polarity: assert property (@(posedge clk_i) disable iff (rst_i)
		alarm_oe_o == (alarm_r != cfg_r.alarm_polarity_bit) && !alarm_o) else $error("alarm pin level wrong");

	chk_comp_alarm_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		(!cfg_r.int_mode && !conv_done_i) |=> $stable(alarm_r))
		else $error("comparator alarm moved without conversion");

	chk_int_read_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		(cfg_r.int_mode && reg_rd_i && !conv_done_i) |=> !alarm_r)
		else $error("read did not clear interrupt alarm");

	chk_standby_no_start: assert property (@(posedge clk_i) disable iff (rst_i)
		(cfg_r.standby && !single_r) |-> !conv_start_o) else $error("conversion started in standby");

	chk_fail_clears_count: assert property (@(posedge clk_i) disable iff (rst_i)
		(conv_done_i && state_r == thermo_pkg::ST_CONV && !cond) |=> cnt_r == 3'h0 && !pending_r)
		else $error("fault counter kept after failed condition");

	chk_alarm_after_count: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(alarm_r) |-> $past(pending_r && conv_done_i && cond))
		else $error("alarm set before fault queue filled");

	// standby entry without a same-cycle activation
	chk_int_standby_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		(conv_done_i && state_r == thermo_pkg::ST_CONV && cfg_r.standby && !in_sb_r && cfg_r.int_mode
		&& !(pending_r && cond)) |=> !alarm_r) else $error("standby entry kept interrupt alarm");

	chk_cmp_standby_keep: assert property (@(posedge clk_i) disable iff (rst_i)
		(conv_done_i && state_r == thermo_pkg::ST_CONV && cfg_r.standby && !cfg_r.int_mode
		&& !(pending_r && cond)) |=> $stable(alarm_r)) else $error("standby entry moved comparator alarm");

	chk_single_consumed: assert property (@(posedge clk_i) disable iff (rst_i)
		(conv_done_i && state_r == thermo_pkg::ST_CONV && !(cfg_wr && reg_wdata_i[thermo_pkg::CFG_SINGLE]))
		|=> !single_r) else $error("single request survived its conversion");

	chk_result_read_only: assert property (@(posedge clk_i) disable iff (rst_i)
		(reg_wr_i && reg_ptr_i == thermo_pkg::PTR_RESULT && !(conv_done_i && state_r == thermo_pkg::ST_CONV))
		|=> $stable(result_r)) else $error("host write changed result");

	chk_over_keep: assert property (@(posedge clk_i) disable iff (rst_i)
		(reg_wr_i && reg_ptr_i == thermo_pkg::PTR_OVER) |=> over_r == $past(reg_wdata_i))
		else $error("over-limit set point lost written value");

	chk_release_keep: assert property (@(posedge clk_i) disable iff (rst_i)
		(reg_wr_i && reg_ptr_i == thermo_pkg::PTR_RELEASE) |=> release_r == $past(reg_wdata_i))
		else $error("release set point lost written value");

	chk_pending_on_count: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(pending_r) |-> ($past(cnt_r) + 3'h1) == fault_target($past(cfg_r.fq)))
		else $error("fault queue armed at wrong count");

	chk_resume_start: assert property (@(posedge clk_i) disable iff (rst_i)
		(state_r == thermo_pkg::ST_IDLE && !cfg_r.standby) |-> conv_start_o)
		else $error("idle without standby did not start a conversion");

	chk_rdata_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		!reg_rd_i |=> $stable(reg_rdata_o))
		else $error("read data moved without a read");

	chk_int_activate: assert property (@(posedge clk_i) disable iff (rst_i)
		(cfg_r.int_mode && conv_done_i && state_r == thermo_pkg::ST_CONV && pending_r && cond) |=> alarm_r)
		else $error("interrupt alarm not raised after fault queue");

	cov_alarm_rise: cover property (@(posedge clk_i) disable iff (rst_i) $rose(alarm_r));
	cov_single_shot: cover property (@(posedge clk_i) disable iff (rst_i)
		single_r && cfg_r.standby ##[1:1000] !single_r);
	cov_int_clear: cover property (@(posedge clk_i) disable iff (rst_i)
		cfg_r.int_mode && alarm_r && reg_rd_i ##1 !alarm_r);

endmodule
`default_nettype wire

// >>> testbench/conv_model.sv
/*
 * Behavioural converter standing at the far side of the conversion port.
 * Assumes one clock shared with the block; answers each start with one done.
 */
`timescale 1ns/1ps
`default_nettype none
module conv_model #(
	parameter int DLY = 20
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        start_i,
	input  wire logic [11:0] raw_i,
	output logic             done_o,
	output logic      [11:0] raw_o
);
	logic     busy_r;
	int       cnt_r;
	// raw is only meaningful with done; otherwise show a value that cannot pass by luck
	assign raw_o = done_o ? raw_i : ~raw_i;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			busy_r <= 1'b0;
			cnt_r  <= 0;
			done_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			if (!busy_r && start_i) begin
				busy_r <= 1'b1;
				cnt_r  <= DLY - 1;
			end else if (busy_r) begin
				if (cnt_r == 0) begin
					busy_r <= 1'b0;
					done_o <= 1'b1;
				end else begin
					cnt_r <= cnt_r - 1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// >>> testbench/testbench.sv
/*
 * Self-checking bench for the thermostat alarm block.
 * Assumes the decoded register port of the design and the converter model beside it.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam int DLY = 20;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [1:0]  ptr = 2'h0;
	logic [15:0] wdata = 16'h0000;
	logic [15:0] rdata;
	logic        start;
	logic        done;
	logic [11:0] raw = 12'h000;
	logic [11:0] raw_q;
	logic        alarm;
	logic        oe;
	int          n_mismatch = 0;
	int          n_compared = 0;
	int          n_done = 0;
	logic [15:0] masks [4] = '{thermo_pkg::MASK_9BIT, thermo_pkg::MASK_10BIT,
		thermo_pkg::MASK_11BIT, thermo_pkg::MASK_12BIT};
	int          faults [4] = '{1, 2, 4, 6};
	localparam logic [11:0] HOT = 12'h510, COLD = 12'h470, MID = 12'h4c0;

	thermo_alarm i_thermo_alarm (.clk_i(clk_i), .rst_i(rst_i), .reg_rd_i(rd), .reg_wr_i(wr), .reg_ptr_i(ptr),
		.reg_wdata_i(wdata), .reg_rdata_o(rdata), .conv_start_o(start), .conv_done_i(done),
		.conv_raw_i(raw_q), .alarm_o(alarm), .alarm_oe_o(oe));
	conv_model #(.DLY(DLY)) i_conv_model (.clk_i(clk_i), .rst_i(rst_i), .start_i(start), .raw_i(raw),
		.done_o(done), .raw_o(raw_q));

	always #20 clk_i = ~clk_i;
	always @(posedge clk_i) if (done === 1'b1) n_done <= n_done + 1;

	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: word %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: pin enable %b expected %b", $time, got, exp);
		end
	endtask
	task automatic wreg(input logic [1:0] p, input logic [15:0] d);
		@(posedge clk_i);
		wr <= 1'b1;
		ptr <= p;
		wdata <= d;
		@(posedge clk_i);
		wr <= 1'b0;
	endtask
	task automatic rdchk(input logic [1:0] p, input logic [15:0] exp);
		@(posedge clk_i);
		rd <= 1'b1;
		ptr <= p;
		@(posedge clk_i);
		rd <= 1'b0;
		#1;
		chk16(rdata, exp);
	endtask
	// raw is never changed on an edge where the block takes a result
	task automatic run(input logic [11:0] v, input int n, input logic exp_oe);
		int target;
		@(posedge clk_i);
		while (done === 1'b1) @(posedge clk_i);
		raw <= v;
		target = n_done + n;
		while (n_done < target) @(posedge clk_i);
		@(posedge clk_i);
		#1;
		chk1(oe, exp_oe);
	endtask
	task automatic quiet;
		int base;
		base = n_done;
		repeat (3 * DLY) @(posedge clk_i);
		n_compared++;
		if (n_done != base) begin
			n_mismatch++;
			$display("Error at %0t: conversion ran in standby", $time);
		end
	endtask

	task automatic t_reset;
		chk1(oe, 1'b0);
		chk1(alarm, 1'b0);
		rdchk(thermo_pkg::PTR_RELEASE, 16'h4800);
		rdchk(thermo_pkg::PTR_OVER, 16'h5000);
		rdchk(thermo_pkg::PTR_CONFIG, 16'h0000);
		wreg(thermo_pkg::PTR_CONFIG, 16'h0004);
		#1 chk1(oe, 1'b1);
		wreg(thermo_pkg::PTR_CONFIG, 16'h0000);
		$display("test reset done");
	endtask
	task automatic t_format;
		for (int r = 0; r < 4; r++) begin
			wreg(thermo_pkg::PTR_CONFIG, 16'h0080 | 16'(r << 5));
			rdchk(thermo_pkg::PTR_CONFIG, 16'(r << 5));
			run(12'he6f, 2, 1'b0);
			wreg(thermo_pkg::PTR_RESULT, 16'hffff);
			rdchk(thermo_pkg::PTR_RESULT, 16'he6f0 & masks[r]);
		end
		wreg(thermo_pkg::PTR_CONFIG, 16'h0000);
		$display("test format done");
	endtask
	task automatic t_comparator;
		for (int q = 0; q < 4; q++) begin
			wreg(thermo_pkg::PTR_CONFIG, 16'(q << 3));
			run(HOT, faults[q], 1'b0);
			run(MID, 1, 1'b0);
			run(HOT, faults[q], 1'b0);
			run(HOT, 1, 1'b1);
			run(COLD, faults[q], 1'b1);
			run(COLD, 1, 1'b0);
		end
		$display("test comparator done");
	endtask
	task automatic t_setpoint;
		wreg(thermo_pkg::PTR_CONFIG, 16'h0000);
		wreg(thermo_pkg::PTR_RELEASE, 16'h48ff);
		rdchk(thermo_pkg::PTR_RELEASE, 16'h48ff);
		run(HOT, 2, 1'b1);
		run(12'h488, 3, 1'b1);
		wreg(thermo_pkg::PTR_RELEASE, thermo_pkg::RELEASE_RST);
		run(COLD, 2, 1'b0);
		wreg(thermo_pkg::PTR_OVER, 16'h50ff);
		run(12'h50c, 3, 1'b0);
		wreg(thermo_pkg::PTR_OVER, thermo_pkg::OVER_RST);
		$display("test set points done");
	endtask
	task automatic t_interrupt;
		wreg(thermo_pkg::PTR_CONFIG, 16'h0002);
		run(HOT, 2, 1'b1);
		rdchk(thermo_pkg::PTR_RESULT, 16'h5100);
		chk1(oe, 1'b0);
		run(HOT, 2, 1'b0);
		run(COLD, 2, 1'b1);
		wreg(thermo_pkg::PTR_CONFIG, 16'h0003);
		run(COLD, 1, 1'b0);
		quiet();
		wreg(thermo_pkg::PTR_CONFIG, 16'h0083);
		run(12'h123, 1, 1'b0);
		rdchk(thermo_pkg::PTR_RESULT, 16'h1200);
		quiet();
		wreg(thermo_pkg::PTR_CONFIG, 16'h0002);
		run(MID, 2, 1'b0);
		$display("test interrupt and standby done");
	endtask
	task automatic t_cmp_standby;
		wreg(thermo_pkg::PTR_CONFIG, 16'h0000);
		run(HOT, 2, 1'b1);
		rdchk(thermo_pkg::PTR_CONFIG, 16'h0000);
		chk1(oe, 1'b1);
		wreg(thermo_pkg::PTR_CONFIG, 16'h0001);
		run(COLD, 1, 1'b1);
		quiet();
		wreg(thermo_pkg::PTR_CONFIG, 16'h0000);
		run(COLD, 2, 1'b0);
		$display("test comparator standby done");
	endtask

	task automatic complete_run;
		$display("compared %0d, mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_format();
		t_comparator();
		t_setpoint();
		t_interrupt();
		t_cmp_standby();
		complete_run();
	end
	// whole run needs roughly 2000 cycles
	initial begin
		#2000000;
		n_mismatch++;
		complete_run();
	end
endmodule
`default_nettype wire
